// file: dacoc_pkg.sv
/*
  Constants shared by the DAC output-state controller: APB offsets,
  serial frame layout, control bit positions and reset values.
  Assumes 24-bit serial frames and a 32-bit APB data bus.
*/
// Notes on behaviour
// - Software control is write-only, acts like pin pulses
// - Load bit updates DAC register and output
// - Clear bit loads DAC register with clear code
// - Clear output follows currently selected code format
// - Reset bit returns everything to power-on state
// - Clear ignored while load pin held low
// - Load ignored while clear pin held low
// - Power-up resets registers, tristates, clamps to ground
// - Power-up state holds until control register written
// - Unprogrammed released output sits at negative reference
// - Clamp bit overrides; tristate alone tristates output
// - Feedback bit one puts resistors in parallel
// - Feedback bit zero puts resistors in series
// - Code format defaults zero, twos complement
// - Frame MSB zero writes, one reads
// - Tristate bit defaults to one after reset
package dacoc_pkg;
  // ----------------------------------------------------------------
  // APB register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] A_INPUT = 12'h000;
  localparam logic [11:0] A_CTRL = 12'h004;
  localparam logic [11:0] A_CLEAR = 12'h008;
  localparam logic [11:0] A_SWCTL = 12'h00c;
  localparam logic [11:0] A_STATUS = 12'h010;
  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int F_RW = 23;
  localparam logic [2:0] SA_DAC = 3'h1;
  localparam logic [2:0] SA_CTRL = 3'h2;
  localparam logic [2:0] SA_CLEAR = 3'h3;
  localparam logic [2:0] SA_SWCTL = 3'h4;
  // ----------------------------------------------------------------
  // Bit positions
  // ----------------------------------------------------------------
  localparam int B_FB_SEL = 1;
  localparam int B_GND_CLAMP = 2;
  localparam int B_TRI_CTL = 3;
  localparam int B_FMT = 4;
  localparam int B_LOAD = 0;
  localparam int B_CLEAR = 1;
  localparam int B_RESET = 2;
  localparam int S_CLAMP = 16;
  localparam int S_TRI = 17;
  // ----------------------------------------------------------------
  // Reset values and code sign mask
  // ----------------------------------------------------------------
  localparam logic [15:0] DAC_RST = 16'h8000;
  localparam logic [15:0] CLEAR_CODE_RST = 16'h0000;
  localparam logic FB_SEL_RST = 1'b1;
  localparam logic GND_CLAMP_RST = 1'b1;
  localparam logic TRI_CTL_RST = 1'b1;
  localparam logic FMT_RST = 1'b0;
  localparam logic [15:0] CODE_SIGN = 16'h8000;
endpackage

// file: dacoc_output_ctl.sv
/*
  DAC output-state controller: serial frame receiver on the link clock,
  APB register slave, load/clear/reset actions and output-state decode.
  Assumes load and clear pins are asynchronous active-low levels and
  that the link clock only runs while the frame select is low.
*/
`timescale 1ns/100ps
`default_nettype none
module dacoc_output_ctl
  import dacoc_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link
  input wire logic link_sclk,
  input wire logic link_sync_n,
  input wire logic link_sdin,
  // Control pins
  input wire logic load_output_update_n,
  input wire logic clear_to_code_n,
  // Analog-side controls
  output logic [15:0] dac_code,
  output logic converter_tristate_ctl,
  output logic output_ground_clamp,
  output logic feedback_resistor_select
);
  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] cnt;
    logic [22:0] shift;
  } dacoc_shf_t;
  typedef struct packed {
    logic [23:0] word;
    logic tgl;
  } dacoc_lk_t;
  dacoc_shf_t sh, next_sh;
  dacoc_lk_t lk, next_lk;
  logic lk_rst_n;
  assign lk_rst_n = presetn & ~link_sync_n;

  always_comb begin
    next_sh = sh;
    next_lk = lk;
    if (sh.cnt < 5'(FRAME_BITS)) begin
      next_sh.cnt = sh.cnt + 5'd1;
      next_sh.shift = {sh.shift[21:0], link_sdin};
    end
    // Word held until the next full frame, far longer than the crossing
    if (sh.cnt == 5'(FRAME_BITS - 1)) begin
      next_lk.word = {sh.shift, link_sdin};
      next_lk.tgl = ~lk.tgl;
    end
  end

  // Frame select doubles as reset so a short frame never leaks bits
  always_ff @(negedge link_sclk or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      sh <= '0;
    end else begin
      sh <= next_sh;
    end
  end

  always_ff @(negedge link_sclk or negedge presetn) begin
    if (!presetn) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // ----------------------------------------------------------------
  // Register domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] fr_sync;
    logic fr_seen;
    logic [1:0] ld_sync;
    logic ld_prev;
    logic [1:0] cl_sync;
    logic cl_prev;
    logic [15:0] input_reg;
    logic [15:0] dac_reg;
    logic [15:0] clear_code;
    logic fb_sel;
    logic gnd_clamp;
    logic tri_ctl;
    logic fmt;
    logic [15:0] o_code;
    logic o_tri;
    logic o_clamp;
    logic o_fb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dacoc_st_t;

  localparam dacoc_st_t ST_RESET = '{
    ld_sync: 2'h3,
    ld_prev: 1'b1,
    cl_sync: 2'h3,
    cl_prev: 1'b1,
    dac_reg: DAC_RST,
    clear_code: CLEAR_CODE_RST,
    fb_sel: FB_SEL_RST,
    gnd_clamp: GND_CLAMP_RST,
    tri_ctl: TRI_CTL_RST,
    fmt: FMT_RST,
    o_code: DAC_RST ^ CODE_SIGN,
    o_tri: 1'b1,
    o_clamp: GND_CLAMP_RST,
    o_fb: FB_SEL_RST,
    default: '0
  };

  dacoc_st_t st, next_st;
  logic frame_go, ser_wr, apb_wr, apb_acc, apb_setup;
  logic [2:0] ser_addr;
  logic sw_load, sw_clear, rst_go, ctl_wr;
  logic load_req, clear_req, load_go, clear_go;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.fr_sync = {st.fr_sync[0], lk.tgl};
    next_st.fr_seen = st.fr_sync[1];
    next_st.ld_sync = {st.ld_sync[0], load_output_update_n};
    next_st.ld_prev = st.ld_sync[1];
    next_st.cl_sync = {st.cl_sync[0], clear_to_code_n};
    next_st.cl_prev = st.cl_sync[1];
    frame_go = st.fr_sync[1] ^ st.fr_seen;
    ser_addr = lk.word[22:20];
    ser_wr = frame_go & ~lk.word[F_RW];
    apb_setup = psel & ~penable;
    apb_acc = psel & penable & st.pready;
    apb_wr = apb_acc & pwrite & ~st.pslverr;
    // Either path acts like a low pulse on the pin
    sw_load = (ser_wr & ser_addr == SA_SWCTL & lk.word[B_LOAD])
      | (apb_wr & paddr == A_SWCTL & pwdata[B_LOAD]);
    sw_clear = (ser_wr & ser_addr == SA_SWCTL & lk.word[B_CLEAR])
      | (apb_wr & paddr == A_SWCTL & pwdata[B_CLEAR]);
    rst_go = (ser_wr & ser_addr == SA_SWCTL & lk.word[B_RESET])
      | (apb_wr & paddr == A_SWCTL & pwdata[B_RESET]);
    ctl_wr = (ser_wr & ser_addr == SA_CTRL) | (apb_wr & paddr == A_CTRL);
    load_req = sw_load | (st.ld_prev & ~st.ld_sync[1]);
    clear_req = sw_clear | (st.cl_prev & ~st.cl_sync[1]);
    load_go = load_req & st.cl_sync[1];
    clear_go = clear_req & st.ld_sync[1];

    // Serial writes first; an APB write in the same cycle wins
    if (ser_wr) begin
      unique case (ser_addr)
        SA_DAC: next_st.input_reg = lk.word[19:4];
        SA_CTRL: begin
          next_st.fb_sel = lk.word[B_FB_SEL];
          next_st.gnd_clamp = lk.word[B_GND_CLAMP];
          next_st.tri_ctl = lk.word[B_TRI_CTL];
          next_st.fmt = lk.word[B_FMT];
        end
        SA_CLEAR: next_st.clear_code = lk.word[19:4];
        default: ;
      endcase
    end
    if (apb_wr) begin
      unique case (paddr)
        A_INPUT: next_st.input_reg = pwdata[15:0];
        A_CTRL: begin
          next_st.fb_sel = pwdata[B_FB_SEL];
          next_st.gnd_clamp = pwdata[B_GND_CLAMP];
          next_st.tri_ctl = pwdata[B_TRI_CTL];
          next_st.fmt = pwdata[B_FMT];
        end
        A_CLEAR: next_st.clear_code = pwdata[15:0];
        default: ;
      endcase
    end

    // Clear outranks load when both arrive together
    if (clear_go) begin
      next_st.dac_reg = st.clear_code;
    end else if (load_go) begin
      next_st.dac_reg = st.input_reg;
    end

    if (rst_go) begin
      next_st.input_reg = '0;
      next_st.dac_reg = DAC_RST;
      next_st.clear_code = CLEAR_CODE_RST;
      next_st.fb_sel = FB_SEL_RST;
      next_st.gnd_clamp = GND_CLAMP_RST;
      next_st.tri_ctl = TRI_CTL_RST;
      next_st.fmt = FMT_RST;
    end

    // Straight binary for the converter; twos complement flips the MSB
    next_st.o_code = next_st.fmt ? next_st.dac_reg
      : next_st.dac_reg ^ CODE_SIGN;
    next_st.o_clamp = next_st.gnd_clamp;
    next_st.o_tri = next_st.tri_ctl | next_st.gnd_clamp;
    next_st.o_fb = next_st.fb_sel;

    // APB: answer one cycle after setup, data latched at setup
    next_st.pready = apb_setup;
    next_st.pslverr = 1'b0;
    next_st.prdata = '0;
    if (apb_setup) begin
      unique case (paddr)
        A_INPUT: next_st.prdata = {16'h0000, st.input_reg};
        A_CTRL: begin
          next_st.prdata[B_FB_SEL] = st.fb_sel;
          next_st.prdata[B_GND_CLAMP] = st.gnd_clamp;
          next_st.prdata[B_TRI_CTL] = st.tri_ctl;
          next_st.prdata[B_FMT] = st.fmt;
        end
        A_CLEAR: next_st.prdata = {16'h0000, st.clear_code};
        A_SWCTL: next_st.prdata = '0;
        A_STATUS: begin
          next_st.prdata[15:0] = st.dac_reg;
          next_st.prdata[S_CLAMP] = st.o_clamp;
          next_st.prdata[S_TRI] = st.o_tri;
        end
        default: next_st.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign dac_code = st.o_code;
  assign converter_tristate_ctl = st.o_tri;
  assign output_ground_clamp = st.o_clamp;
  assign feedback_resistor_select = st.o_fb;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_load_update: assert property (@(posedge pclk) disable iff (!presetn)
    load_go && !clear_go && !rst_go |=> st.dac_reg == $past(st.input_reg))
    else $error("load did not move input to dac register");
  a_clear_code: assert property (@(posedge pclk) disable iff (!presetn)
    clear_go && !rst_go |=> st.dac_reg == $past(st.clear_code))
    else $error("clear did not load clear code");
  a_code_format: assert property (@(posedge pclk) disable iff (!presetn)
    dac_code == (st.fmt ? st.dac_reg : {~st.dac_reg[15], st.dac_reg[14:0]}))
    else $error("output code ignores format");
  a_soft_reset: assert property (@(posedge pclk) disable iff (!presetn)
    rst_go |=> converter_tristate_ctl && output_ground_clamp
      && st.tri_ctl && !st.fmt && st.dac_reg == DAC_RST)
    else $error("soft reset left state altered");
  a_clear_block: assert property (@(posedge pclk) disable iff (!presetn)
    clear_req && !st.ld_sync[1] && !load_go && !rst_go |=> $stable(st.dac_reg))
    else $error("clear acted while load pin low");
  a_load_block: assert property (@(posedge pclk) disable iff (!presetn)
    load_req && !st.cl_sync[1] && !clear_go && !rst_go |=> $stable(st.dac_reg))
    else $error("load acted while clear pin low");
  a_power_on: assert property (@(posedge pclk)
    $rose(presetn) |-> output_ground_clamp && converter_tristate_ctl
      && feedback_resistor_select)
    else $error("power-on state wrong");
  a_state_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !ctl_wr && !rst_go |=> $stable(st.gnd_clamp) && $stable(st.tri_ctl))
    else $error("output state changed without control write");
  a_neg_ref: assert property (@(posedge pclk) disable iff (!presetn)
    rst_go ##1 !load_go && !clear_go && !ctl_wr |=> dac_code == 16'h0000)
    else $error("default code not at negative reference");
  a_state_decode: assert property (@(posedge pclk) disable iff (!presetn)
    output_ground_clamp == st.gnd_clamp
      && converter_tristate_ctl == (st.tri_ctl || st.gnd_clamp))
    else $error("output state decode wrong");
  a_fb_select: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_wr && !rst_go && !apb_wr |=> feedback_resistor_select
      == $past(lk.word[B_FB_SEL]))
    else $error("feedback select does not follow control");
  a_read_nowrite: assert property (@(posedge pclk) disable iff (!presetn)
    frame_go && lk.word[F_RW] && !apb_wr |=> $stable(st.input_reg)
      && $stable(st.clear_code))
    else $error("read frame wrote a register");
  a_clear_field: assert property (@(posedge pclk) disable iff (!presetn)
    ser_wr && ser_addr == SA_CLEAR && !apb_wr && !rst_go
      |=> st.clear_code == $past(lk.word[19:4]))
    else $error("clear code field misplaced");
  a_swctl_zero: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup && !pwrite && paddr == A_SWCTL |=> pready && prdata == 32'h0)
    else $error("control strobe register readable");
endmodule // dacoc_output_ctl
`default_nettype wire

// file: dacoc_host_model.sv
/*
  Host model for the serial link: sends 24-bit frames, MSB first.
  Assumes the receiver samples data on the falling link clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module dacoc_host_model (
  // Serial link
  output logic link_sclk,
  output logic link_sync_n,
  output logic link_sdin
);
  initial begin
    link_sclk = 1'h1;
    link_sync_n = 1'h1;
    link_sdin = 1'h0;
  end
  // Clock stands high between frames; 48 ns period inside them
  task automatic send(input logic [23:0] f);
    #3;
    link_sync_n = 1'h0;
    for (int i = 23; i >= 0; i--) begin
      link_sdin = f[i];
      #24 link_sclk = 1'h0;
      #24 link_sclk = 1'h1;
    end
    #24 link_sync_n = 1'h1;
    // Released line shows the inverse so a stale bit cannot pass
    link_sdin = ~f[0];
  endtask
endmodule // dacoc_host_model
`default_nettype wire

// file: test_dacoc_output_ctl.sv
/*
  Self-checking bench for the DAC output-state controller.
  Assumes the host model drives the serial link and APB runs on pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module test_dacoc_output_ctl import dacoc_pkg::*; ;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, s;
  logic lsclk, lsync_n, lsdin, ld_n, clr_n, tri_o, gnd_o, fb_o;
  logic [15:0] dac_code, dreg, v, c;
  int error_cnt = 0;
  int n_checks = 0;
  dacoc_output_ctl i_dacoc_output_ctl (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_sclk(lsclk), .link_sync_n(lsync_n), .link_sdin(lsdin),
    .load_output_update_n(ld_n), .clear_to_code_n(clr_n),
    .dac_code(dac_code), .converter_tristate_ctl(tri_o),
    .output_ground_clamp(gnd_o), .feedback_resistor_select(fb_o));
  dacoc_host_model i_dacoc_host_model (.link_sclk(lsclk),
    .link_sync_n(lsync_n), .link_sdin(lsdin));
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  // Format zero is twos complement: converter sees the sign bit flipped
  function automatic logic [15:0] conv(input logic [15:0] r, input logic f);
    return f ? r : r ^ CODE_SIGN;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) error_cnt++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Fixed wait covers the pin sync and link crossing latencies
  task automatic settle();
    repeat (10) @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
    settle();
  endtask
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(n, e, rdat);
  endtask
  task automatic outs(input logic [15:0] cd, input logic t, input logic g, input logic f);
    chk("outputs", {13'h0, cd, t, g, f}, {13'h0, dac_code, tri_o, gnd_o, fb_o});
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    // Whole run needs under a thousand cycles; this stays well under the budget
    #500000;
    error_cnt++;
    test_done();
  end
  initial begin
    s = 32'h60;
    {psel, penable, pwrite, presetn} = 4'h0;
    {paddr, pwdata} = '0;
    {ld_n, clr_n} = 2'h3;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    settle();
    outs(16'h0, 1'h1, 1'h1, 1'h1);
    rdc("control", A_CTRL, 32'he);
    rdc("status", A_STATUS, 32'h38000);
    dreg = DAC_RST;
    wr(A_INPUT, 32'h1234);
    outs(16'h0, 1'h1, 1'h1, 1'h1);
    wr(A_CTRL, 32'h0);
    outs(16'h0, 1'h0, 1'h0, 1'h0);
    for (int k = 0; k < 4; k++) begin
      wr(A_CTRL, {28'h0, k[1], k[0], k[0], 1'h0});
      outs(16'h0, k[1] | k[0], k[0], k[0]);
    end
    for (int f = 0; f < 2; f++) begin
      wr(A_CTRL, {27'h0, f[0], 4'h0});
      v = rnd();
      wr(A_INPUT, {16'h0, v});
      outs(conv(dreg, f[0]), 1'h0, 1'h0, 1'h0);
      wr(A_SWCTL, 32'h1);
      dreg = v;
      outs(conv(dreg, f[0]), 1'h0, 1'h0, 1'h0);
      c = rnd();
      wr(A_CLEAR, {16'h0, c});
      wr(A_SWCTL, 32'h2);
      dreg = c;
      outs(conv(dreg, f[0]), 1'h0, 1'h0, 1'h0);
    end
    rdc("strobes", A_SWCTL, 32'h0);
    ld_n <= 1'h0;
    settle();
    outs(v, 1'h0, 1'h0, 1'h0);
    wr(A_SWCTL, 32'h2);
    clr_n <= 1'h0;
    settle();
    outs(v, 1'h0, 1'h0, 1'h0);
    ld_n <= 1'h1;
    wr(A_INPUT, {16'h0, ~v});
    wr(A_SWCTL, 32'h1);
    outs(v, 1'h0, 1'h0, 1'h0);
    clr_n <= 1'h1;
    settle();
    clr_n <= 1'h0;
    settle();
    clr_n <= 1'h1;
    outs(c, 1'h0, 1'h0, 1'h0);
    c = rnd();
    i_dacoc_host_model.send({1'h0, SA_CLEAR, c, v[3:0]});
    settle();
    rdc("clear", A_CLEAR, {16'h0, c});
    i_dacoc_host_model.send({1'h1, SA_CLEAR, ~c, 4'h0});
    settle();
    rdc("clear", A_CLEAR, {16'h0, c});
    i_dacoc_host_model.send({1'h0, SA_SWCTL, 16'h0, 4'h2});
    i_dacoc_host_model.send({1'h0, SA_CTRL, 16'h0, 4'h8});
    settle();
    outs(c ^ CODE_SIGN, 1'h1, 1'h0, 1'h0);
    apb(1'h0, 12'h020, 32'h0);
    chk("slverr", 32'h1, {31'h0, rerr});
    chk("rdata", 32'h0, rdat);
    wr(A_SWCTL, 32'h4);
    outs(16'h0, 1'h1, 1'h1, 1'h1);
    rdc("control", A_CTRL, 32'he);
    test_done();
  end
endmodule // test_dacoc_output_ctl
`default_nettype wire
